// ### common/sys_pin_pkg.sv
// Package for the system pin control block
package sys_pin_pkg;
    localparam int unsigned SYS_CLK_HZ = 20000000;
    localparam int unsigned PC_W = 16;
    localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
    localparam int unsigned CTRL_W = 16;
    localparam int unsigned CLK_SEL_BIT = 14;
    localparam int unsigned BOOT_EN_BIT = 3;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 16'h0000;
    // Watchdog reset pulse width on the reset pin, in ns
    localparam int unsigned WD_PULSE_NS = 2000;
    localparam int unsigned WD_PULSE_CYC = (WD_PULSE_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned WD_CNT_W = 8;
    localparam int unsigned PWM_W = 8;

    typedef struct packed {
        logic [PWM_W-1:0] out;
        logic [PWM_W-1:0] oe;
    } pwm_bus_t;

    typedef struct packed {
        logic in;
        logic out;
        logic oe;
    } pin_io_t;

    typedef enum logic [2:0] {
        ST_RESET = 3'h1,
        ST_RUN = 3'h2,
        ST_WD_PULSE = 3'h4
    } rst_state_t;
endpackage

// ### tb/sp_board.sv
// Board model: reset line with pull-up and passive boot strap
`timescale 1ns/1ps
`default_nettype none
module sp_board (
    input wire logic i_hold_reset, // Board pulls reset low
    input wire logic i_dev_rst_oe, // Device drives reset pin
    input wire logic i_dev_rst_n, // Device reset level
    input wire logic i_strap_high, // Strap resistor level
    input wire logic i_flag_oe, // Device drives strap pin
    input wire logic i_flag_out, // Device flag level
    output logic o_reset_pin_n, // Resolved reset pin
    output logic o_strap_pin // Resolved strap pin
);
    assign o_reset_pin_n = !i_hold_reset && !(i_dev_rst_oe && !i_dev_rst_n);
    // Resistor only, so the device wins once it drives
    assign o_strap_pin = i_flag_oe ? i_flag_out : i_strap_high;
endmodule
`default_nettype wire

// ### tb/sys_pin_checker.sv
// Concurrent checks on the system pin control ports
`timescale 1ns/1ps
`default_nettype none
module sys_pin_checker
    import sys_pin_pkg::*;
(
    input wire logic i_sys_clk, i_reset_n, i_wd_overflow, i_drive_protect_a_n, // Clock, reset, causes
    input wire logic i_drive_protect_b_n, i_ext_irq_two, i_irq_two_rise, i_irq_two_en, // Pin causes
    input wire logic i_clock_out_en, i_test_output_disable_n, i_test_reset, i_emulator_pin_zero, // Selects
    input wire logic [CTRL_W-1:0] i_system_ctrl_status, // Control word
    input wire logic o_cpu_run, o_system_reset_oe, o_protect_irq_a, o_protect_irq_b, o_ext_irq_two, // Events
    input wire logic o_clock_out_pin, o_external_flag_out, o_external_flag_oe, o_crystal_oe, // Drive
    input wire logic o_gpio_a_bit2_oe, o_gpio_d_bit0_oe, // GPIO enables
    input wire logic [PC_W-1:0] o_program_counter, // Fetch address
    input wire pwm_bus_t o_pwm_a, o_pwm_b // PWM pins
);
    default clocking dclk @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_reset_n);
    property p_pc_held; !o_cpu_run [*2] |-> o_program_counter == PC_RESET; endproperty
    a_pc_held: assert property (p_pc_held) else $error("fetch address not zero while halted");
    property p_run_entry; $rose(o_cpu_run) |-> o_program_counter == PC_RESET && o_external_flag_out
        && o_external_flag_oe && !o_gpio_a_bit2_oe && !o_gpio_d_bit0_oe; endproperty
    a_run_entry: assert property (p_run_entry) else $error("bad state at run entry");
    property p_wd; i_wd_overflow && o_cpu_run |=> o_system_reset_oe && !o_cpu_run ##39 o_system_reset_oe
        ##1 !o_system_reset_oe; endproperty
    a_wd: assert property (p_wd) else $error("reset pulse wrong");
    property p_prot_a; $fell(i_drive_protect_a_n) |-> ##[1:4] o_protect_irq_a ##1 o_pwm_a.oe == '0; endproperty
    a_prot_a: assert property (p_prot_a) else $error("protect a not taken");
    property p_prot_b; $fell(i_drive_protect_b_n) |-> ##[1:4] o_protect_irq_b ##1 o_pwm_b.oe == '0; endproperty
    a_prot_b: assert property (p_prot_b) else $error("protect b not taken");
    property p_irq_two; $changed(i_ext_irq_two) && i_ext_irq_two == i_irq_two_rise && i_irq_two_en
        |-> ##[1:4] o_ext_irq_two; endproperty
    a_irq_two: assert property (p_irq_two) else $error("interrupt two edge missed");
    property p_clk; (i_clock_out_en && !i_system_ctrl_status[CLK_SEL_BIT]) [*3]
        |-> o_clock_out_pin != $past(o_clock_out_pin); endproperty
    a_clk: assert property (p_clk) else $error("cpu clock not on pin");
    property p_xtal; $stable({i_test_output_disable_n, i_test_reset, i_emulator_pin_zero}) [*5]
        |-> o_crystal_oe == !(!i_test_output_disable_n && !i_test_reset && i_emulator_pin_zero); endproperty
    a_xtal: assert property (p_xtal) else $error("crystal enable wrong");
    c_wd: cover property (o_system_reset_oe);
    c_prot: cover property (o_protect_irq_b);
    c_irq: cover property (o_ext_irq_two);
endmodule
bind system_pin_control sys_pin_checker chk (.*);
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the system pin control block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sys_pin_pkg::*;
    logic i_sys_clk, i_reset_n, i_system_reset_n, o_system_reset_n, o_system_reset_oe, i_wd_overflow, o_cpu_run,
        i_fetch_advance, i_drive_protect_a_n, i_drive_protect_b_n, i_protect_clear_a, i_protect_clear_b,
        o_protect_irq_a, o_protect_irq_b, i_ext_irq_one, i_ext_irq_two, i_irq_one_rise, i_irq_two_rise,
        i_irq_one_en, i_irq_two_en, i_adc_trig_en, o_ext_irq_one, o_ext_irq_two, o_adc_conv_trigger,
        i_gpio_dir_wr, o_gpio_a_bit2_oe, o_gpio_a_bit2_out, o_gpio_d_bit0_oe, o_gpio_d_bit0_out,
        i_clock_out_en, i_watchdog_clock, o_clock_out_pin, o_clock_out_oe, i_boot_en_pin, i_flag_value,
        i_flag_wr, o_external_flag_out, o_external_flag_oe, i_test_output_disable_n, i_test_reset,
        i_emulator_pin_zero, i_crystal_osc, o_crystal_out, o_crystal_oe, hold_rst, strap;
    logic [PC_W-1:0] o_program_counter;
    logic [CTRL_W-1:0] i_system_ctrl_status, o_system_ctrl_status_two;
    pwm_bus_t i_pwm_a, i_pwm_b, o_pwm_a, o_pwm_b;
    pin_io_t i_gpio_a_bit2, i_gpio_d_bit0, i_gpio_e_bit0;
    int fail_count, checks_done, n;
    int cnt [7];
    system_pin_control dut (.*);
    sp_board board (.i_hold_reset(hold_rst), .i_dev_rst_oe(o_system_reset_oe), .i_dev_rst_n(o_system_reset_n),
        .i_strap_high(strap), .i_flag_oe(o_external_flag_oe), .i_flag_out(o_external_flag_out),
        .o_reset_pin_n(i_system_reset_n), .o_strap_pin(i_boot_en_pin));
    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = ~i_sys_clk;
    end
    task automatic step(input int k);
        repeat (k) begin
            @(posedge i_sys_clk);
            #1 i_crystal_osc = 1'($urandom);
        end
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h, want %h", $time, got, exp);
        end
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return o_ext_irq_one;
            1: return o_ext_irq_two;
            2: return o_adc_conv_trigger;
            3: return o_protect_irq_a;
            4: return o_protect_irq_b;
            5: return o_system_reset_oe;
            default: return o_clock_out_pin;
        endcase
    endfunction
    // Cycles each watched output spends high over k cycles
    task automatic count(input int k);
        cnt = '{default: 0};
        repeat (k) begin
            for (int s = 0; s < 7; s++) cnt[s] += int'(pick(s) === 1'b1);
            step(1);
        end
    endtask
    task automatic wait_run();
        n = 0;
        while (o_cpu_run !== 1'b1 && n < 60) begin
            step(1);
            n++;
        end
        chk(o_cpu_run, 1'b1);
        chk(o_program_counter, PC_RESET);
    endtask
    task automatic board_reset(input logic s);
        strap = s;
        hold_rst = 1'b1;
        step(5);
        chk(o_cpu_run, 1'b0);
        chk(o_program_counter, PC_RESET);
        hold_rst = 1'b0;
        wait_run();
        chk(o_system_ctrl_status_two, 16'(s) << BOOT_EN_BIT);
        chk(o_external_flag_out, 1'b1);
        chk(o_gpio_d_bit0_oe, 1'b0);
    endtask
    task automatic close_out();
        $display("checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    initial begin
        #(20000 * 50);
        fail_count++;
        close_out();
    end
    initial begin
        {i_reset_n, i_wd_overflow, i_fetch_advance, i_protect_clear_a, i_protect_clear_b, i_irq_one_rise,
            i_irq_two_rise, i_irq_one_en, i_irq_two_en, i_adc_trig_en, i_gpio_dir_wr, i_clock_out_en,
            i_watchdog_clock, i_flag_value, i_flag_wr, i_test_reset, i_crystal_osc, hold_rst, strap} = '0;
        {i_drive_protect_a_n, i_drive_protect_b_n, i_ext_irq_one, i_ext_irq_two, i_test_output_disable_n,
            i_emulator_pin_zero} = '1;
        {i_pwm_a, i_pwm_b, i_system_ctrl_status, i_gpio_a_bit2, i_gpio_d_bit0, i_gpio_e_bit0} = '0;
        fail_count = 0;
        checks_done = 0;
        void'($urandom(8));
        step(2);
        i_reset_n = 1'b1;
        for (int s = 0; s < 2; s++) board_reset(1'(s));
        n = $urandom_range(40, 5);
        i_fetch_advance = 1'b1;
        step(n);
        i_fetch_advance = 1'b0;
        step(1);
        chk(o_program_counter, 16'(n));
        i_wd_overflow = 1'b1;
        step(1);
        i_wd_overflow = 1'b0;
        chk({o_system_reset_oe, o_system_reset_n}, 2'h2);
        count(60);
        chk(16'(cnt[5]), 16'(WD_PULSE_CYC));
        wait_run();
        for (int ch = 0; ch < 2; ch++) begin
            i_pwm_a = 16'($urandom | 32'h1);
            i_pwm_b = 16'($urandom | 32'h1);
            step(2);
            chk(ch ? o_pwm_b : o_pwm_a, ch ? i_pwm_b : i_pwm_a);
            if (ch) i_drive_protect_b_n = 1'b0;
            else i_drive_protect_a_n = 1'b0;
            count(6);
            chk(16'(cnt[3 + ch]), 16'h0001);
            chk(ch ? o_pwm_b.oe : o_pwm_a.oe, 16'h0000);
            chk(ch ? o_pwm_a.oe : o_pwm_b.oe, ch ? i_pwm_a.oe : i_pwm_b.oe);
            {i_drive_protect_a_n, i_drive_protect_b_n, i_protect_clear_a, i_protect_clear_b} = 4'hf;
            step(4);
            chk(ch ? o_pwm_b : o_pwm_a, ch ? i_pwm_b : i_pwm_a);
            {i_protect_clear_a, i_protect_clear_b} = 2'h0;
        end
        {i_irq_one_en, i_irq_two_en, i_adc_trig_en} = 3'h7;
        for (int p = 1; p >= 0; p--) begin
            {i_irq_one_rise, i_irq_two_rise} = {2{p[0]}};
            {i_ext_irq_one, i_ext_irq_two} = {2{~p[0]}};
            count(6);
            chk(16'(cnt[0] + cnt[1] + cnt[2]), 16'h0000);
            {i_ext_irq_one, i_ext_irq_two} = {2{p[0]}};
            count(6);
            chk(16'(cnt[0] + cnt[1]), 16'h0002);
            chk(16'(cnt[2]), 16'h0001);
        end
        {i_irq_two_en, i_adc_trig_en, i_gpio_dir_wr, i_ext_irq_two} = 4'h3;
        {i_gpio_d_bit0, i_gpio_e_bit0} = 6'h1b;
        step(1);
        {i_gpio_dir_wr, i_ext_irq_two} = 2'h0;
        count(6);
        chk(16'(cnt[1] + cnt[2]), 16'h0000);
        chk(o_gpio_d_bit0_oe, 1'b1);
        chk(o_gpio_d_bit0_out, 1'b1);
        chk(o_clock_out_oe, 1'b1);
        i_system_ctrl_status = 16'($urandom);
        i_system_ctrl_status[CLK_SEL_BIT] = 1'b0;
        i_clock_out_en = 1'b1;
        step(2);
        count(8);
        chk(16'(cnt[6]), 16'h0004);
        i_system_ctrl_status[CLK_SEL_BIT] = 1'b1;
        i_watchdog_clock = 1'b1;
        step(5);
        chk(o_clock_out_pin, 1'b1);
        {i_test_output_disable_n, i_test_reset, i_emulator_pin_zero} = 3'h1;
        step(6);
        chk(o_crystal_oe, 1'b0);
        for (int t = 0; t < 3; t++) begin
            {i_test_output_disable_n, i_test_reset, i_emulator_pin_zero} = 3'h1 ^ (3'h4 >> t);
            step(6);
            chk(o_crystal_oe, 1'b1);
        end
        {i_flag_value, i_flag_wr} = 2'h1;
        step(1);
        i_flag_wr = 1'b0;
        chk(o_external_flag_out, 1'b0);
        board_reset(1'($urandom));
        close_out();
    end
endmodule
`default_nettype wire

// ### verilog/edge_event.sv
// Synchroniser and polarity-selectable edge detector
`timescale 1ns/1ps
`default_nettype none
module edge_event (
    input wire logic i_sys_clk, // System clock
    input wire logic i_reset_n, // Synchronous reset, active low
    input wire logic i_pin, // Asynchronous pin level
    input wire logic i_rise, // 1 = rising edge, 0 = falling edge
    output logic o_event // One-cycle event pulse
);
    logic sync1_q;
    logic sync2_q;
    logic prev_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            sync1_q <= i_pin;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    assign o_event = i_rise ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);
endmodule
`default_nettype wire

// ### verilog/system_pin_control.sv
// System pin control: reset, protection, external interrupts, clock out, boot strap
//
// Functional notes
// - Reset low halts execution and forces program counter to zero.
// - Reset release starts fetching from program address zero.
// - Watchdog overflow drives a reset pulse out onto the reset pin.
// - Falling edge on protect A raises interrupt and tri-states manager A PWM.
// - Falling edge on protect B raises interrupt and tri-states manager B PWM.
// - External interrupts one and two are edge-triggered, polarity software selected.
// - Interrupt two pin also triggers ADC conversion, or is general I/O.
// - Clock output carries CPU clock divided by two or watchdog clock by control bit 14.
// - Clock output pin serves as general I/O when clock out is unwanted.
// - Boot-enable strap sampled during reset into second control bit 3.
// - After reset, boot-enable pin becomes flag output driven high.
// - All general I/O pins default to input after reset.
// - Crystal output tri-states when output-disable and test reset are low and emulator pin zero is high.
// - Output disable needs disable low, test reset low, emulator pin high.
`timescale 1ns/1ps
`default_nettype none
module system_pin_control
    import sys_pin_pkg::*;
(
    input wire logic i_sys_clk, // 20 MHz CPU clock
    input wire logic i_reset_n, // Synchronous reset, active low
    input wire logic i_system_reset_n, // Reset pin input level
    output logic o_system_reset_n, // Reset pin output level
    output logic o_system_reset_oe, // Reset pin output enable
    input wire logic i_wd_overflow, // Watchdog overflow pulse
    output logic o_cpu_run, // CPU may execute
    output logic [PC_W-1:0] o_program_counter, // Fetch address
    input wire logic i_fetch_advance, // CPU advances fetch address
    input wire logic i_drive_protect_a_n, // Protect input A pin
    input wire logic i_drive_protect_b_n, // Protect input B pin
    input wire logic i_protect_clear_a, // Release manager A outputs
    input wire logic i_protect_clear_b, // Release manager B outputs
    output logic o_protect_irq_a, // Protect A interrupt pulse
    output logic o_protect_irq_b, // Protect B interrupt pulse
    input wire pwm_bus_t i_pwm_a, // Manager A PWM request
    input wire pwm_bus_t i_pwm_b, // Manager B PWM request
    output pwm_bus_t o_pwm_a, // Manager A PWM pins
    output pwm_bus_t o_pwm_b, // Manager B PWM pins
    input wire logic i_ext_irq_one, // Interrupt one pin
    input wire logic i_ext_irq_two, // Interrupt two pin
    input wire logic i_irq_one_rise, // Interrupt one polarity
    input wire logic i_irq_two_rise, // Interrupt two polarity
    input wire logic i_irq_one_en, // Pin used as interrupt one
    input wire logic i_irq_two_en, // Pin used as interrupt two
    input wire logic i_adc_trig_en, // Pin used as ADC trigger
    output logic o_ext_irq_one, // Interrupt one pulse
    output logic o_ext_irq_two, // Interrupt two pulse
    output logic o_adc_conv_trigger, // ADC start pulse
    input wire pin_io_t i_gpio_a_bit2, // Interrupt one pin as GPIO
    input wire pin_io_t i_gpio_d_bit0, // Interrupt two pin as GPIO
    input wire pin_io_t i_gpio_e_bit0, // Clock out pin as GPIO
    input wire logic i_gpio_dir_wr, // Software writes GPIO directions
    output logic o_gpio_a_bit2_oe, // Output enable
    output logic o_gpio_a_bit2_out, // Output data
    output logic o_gpio_d_bit0_oe, // Output enable
    output logic o_gpio_d_bit0_out, // Output data
    input wire logic [CTRL_W-1:0] i_system_ctrl_status, // Control register value
    input wire logic i_clock_out_en, // Pin used as clock out
    input wire logic i_watchdog_clock, // Watchdog clock level
    output logic o_clock_out_pin, // Clock out pin data
    output logic o_clock_out_oe, // Clock out pin enable
    input wire logic i_boot_en_pin, // Boot strap pin level
    input wire logic i_flag_value, // Flag value from CPU
    input wire logic i_flag_wr, // Flag write strobe
    output logic [CTRL_W-1:0] o_system_ctrl_status_two, // Second control register
    output logic o_external_flag_out, // Flag pin data
    output logic o_external_flag_oe, // Flag pin enable
    input wire logic i_test_output_disable_n, // Output disable pin
    input wire logic i_test_reset, // JTAG test reset
    input wire logic i_emulator_pin_zero, // Emulator pin zero
    input wire logic i_crystal_osc, // Oscillator drive
    output logic o_crystal_out, // Crystal output data
    output logic o_crystal_oe // Crystal output enable
);
    import sys_pin_pkg::*;

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    logic rst_s1_q, rst_s2_q, boot_s1_q, boot_s2_q, wd_s1_q, wd_s2_q;
    logic off_s1_q, off_s2_q, trst_s1_q, trst_s2_q, emu_s1_q, emu_s2_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            {rst_s1_q, rst_s2_q, boot_s1_q, boot_s2_q} <= 4'h0;
            {wd_s1_q, wd_s2_q, off_s1_q, off_s2_q} <= 4'hf;
            {trst_s1_q, trst_s2_q, emu_s1_q, emu_s2_q} <= 4'hf;
        end else begin
            rst_s1_q <= i_system_reset_n;
            rst_s2_q <= rst_s1_q;
            boot_s1_q <= i_boot_en_pin;
            boot_s2_q <= boot_s1_q;
            wd_s1_q <= i_watchdog_clock;
            wd_s2_q <= wd_s1_q;
            off_s1_q <= i_test_output_disable_n;
            off_s2_q <= off_s1_q;
            trst_s1_q <= i_test_reset;
            trst_s2_q <= trst_s1_q;
            emu_s1_q <= i_emulator_pin_zero;
            emu_s2_q <= emu_s1_q;
        end
    end

    // ----------------------------------------
    // Reset sequencing
    // ----------------------------------------
    rst_state_t state_q;
    logic [WD_CNT_W-1:0] pulse_cnt_q;
    logic [PC_W-1:0] pc_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            state_q <= ST_RESET;
            pulse_cnt_q <= '0;
        end else begin
            unique case (state_q)
                ST_RESET: begin
                    if (rst_s2_q) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (i_wd_overflow) begin
                        state_q <= ST_WD_PULSE;
                        pulse_cnt_q <= WD_CNT_W'(WD_PULSE_CYC - 1);
                    end else if (!rst_s2_q) begin
                        state_q <= ST_RESET;
                    end
                end
                ST_WD_PULSE: begin
                    if (pulse_cnt_q == '0) begin
                        state_q <= ST_RESET;
                    end else begin
                        pulse_cnt_q <= pulse_cnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    logic running;
    assign running = (state_q == ST_RUN) && rst_s2_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n || !running) begin
            pc_q <= PC_RESET;
        end else if (i_fetch_advance) begin
            pc_q <= pc_q + 1'b1;
        end
    end

    assign o_cpu_run = running;
    assign o_program_counter = pc_q;
    assign o_system_reset_n = 1'b0;
    assign o_system_reset_oe = (state_q == ST_WD_PULSE);

    // ----------------------------------------
    // Power drive protection
    // ----------------------------------------
    logic prot_a_ev, prot_b_ev, trip_a_q, trip_b_q, irq1_ev, irq2_ev;
    logic [3:0] edge_pin, edge_rise, edge_ev;

    // One synchronised edge detector per protect and interrupt pin
    assign edge_pin = {i_ext_irq_two, i_ext_irq_one, i_drive_protect_b_n, i_drive_protect_a_n};
    assign edge_rise = {i_irq_two_rise, i_irq_one_rise, 2'h0};
    assign {irq2_ev, irq1_ev, prot_b_ev, prot_a_ev} = edge_ev;

    for (genvar g = 0; g < 4; g++) begin : g_edge
        edge_event u_edge (
            .i_sys_clk(i_sys_clk),
            .i_reset_n(i_reset_n),
            .i_pin(edge_pin[g]),
            .i_rise(edge_rise[g]),
            .o_event(edge_ev[g])
        );
    end

    // Set wins over clear
    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            trip_a_q <= 1'b0;
            trip_b_q <= 1'b0;
        end else begin
            trip_a_q <= prot_a_ev | (trip_a_q & ~i_protect_clear_a);
            trip_b_q <= prot_b_ev | (trip_b_q & ~i_protect_clear_b);
        end
    end

    assign o_protect_irq_a = prot_a_ev;
    assign o_protect_irq_b = prot_b_ev;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_pwm_a <= '0;
            o_pwm_b <= '0;
        end else begin
            o_pwm_a.out <= i_pwm_a.out;
            o_pwm_b.out <= i_pwm_b.out;
            o_pwm_a.oe <= (trip_a_q | prot_a_ev) ? '0 : i_pwm_a.oe;
            o_pwm_b.oe <= (trip_b_q | prot_b_ev) ? '0 : i_pwm_b.oe;
        end
    end

    // ----------------------------------------
    // External interrupts and ADC trigger
    // ----------------------------------------
    assign o_ext_irq_one = irq1_ev & i_irq_one_en;
    assign o_ext_irq_two = irq2_ev & i_irq_two_en;
    assign o_adc_conv_trigger = irq2_ev & i_adc_trig_en;

    // ----------------------------------------
    // General I/O direction
    // ----------------------------------------
    logic [2:0] gpio_oe_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n || !running) begin
            gpio_oe_q <= 3'h0;
        end else if (i_gpio_dir_wr) begin
            gpio_oe_q <= {i_gpio_e_bit0.oe, i_gpio_d_bit0.oe, i_gpio_a_bit2.oe};
        end
    end

    assign o_gpio_a_bit2_oe = gpio_oe_q[0] & ~i_irq_one_en;
    assign o_gpio_a_bit2_out = i_gpio_a_bit2.out;
    assign o_gpio_d_bit0_oe = gpio_oe_q[1] & ~i_irq_two_en & ~i_adc_trig_en;
    assign o_gpio_d_bit0_out = i_gpio_d_bit0.out;

    // ----------------------------------------
    // Clock output
    // ----------------------------------------
    logic sys_phase_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            sys_phase_q <= 1'b0;
        end else begin
            sys_phase_q <= ~sys_phase_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            o_clock_out_pin <= 1'b0;
        end else if (i_clock_out_en) begin
            o_clock_out_pin <= i_system_ctrl_status[CLK_SEL_BIT] ? wd_s2_q : sys_phase_q;
        end else begin
            o_clock_out_pin <= i_gpio_e_bit0.out;
        end
    end

    assign o_clock_out_oe = i_clock_out_en | (gpio_oe_q[2] & running);

    // ----------------------------------------
    // Boot strap and flag
    // ----------------------------------------
    logic [CTRL_W-1:0] ctrl2_q;
    logic flag_q;

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n) begin
            ctrl2_q <= CTRL_RESET;
        end else if (!running) begin
            ctrl2_q[BOOT_EN_BIT] <= boot_s2_q;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_reset_n || !running) begin
            flag_q <= 1'b1;
        end else if (i_flag_wr) begin
            flag_q <= i_flag_value;
        end
    end

    assign o_system_ctrl_status_two = ctrl2_q;
    assign o_external_flag_out = flag_q;
    assign o_external_flag_oe = running;

    // ----------------------------------------
    // Crystal output disable
    // ----------------------------------------
    logic off_active;
    assign off_active = ~off_s2_q & ~trst_s2_q & emu_s2_q;
    assign o_crystal_out = i_crystal_osc;
    assign o_crystal_oe = ~off_active;
endmodule
`default_nettype wire
